/* src/ilsc_ctrl.sv */
/*
  Interrupt priority, return stack and hardware loop control.
  Assumes the sequencer gives one-cycle command pulses, applies loop_jump
  the cycle after it is seen and never issues two stack commands at once.
*/
`timescale 1ns/1ns
`default_nettype none
module ilsc_ctrl
  import ilsc_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [4:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [15:0] io_wdata,
  output logic [15:0] io_rdata,
  input wire ilsc_seq_cmd_t seq_cmd,
  input wire logic [15:0] push_data,
  input wire logic [15:0] status_in,
  output logic [15:0] pop_data,
  output logic status_restore,
  output logic global_irq_mask,
  input wire ilsc_flow_cmd_t flow_cmd,
  input wire logic [15:0] loop_addr,
  input wire logic fetch_valid,
  input wire logic [15:0] fetch_pc,
  output logic loop_jump,
  output logic [15:0] loop_target,
  output logic flow_busy,
  input wire logic instr_done,
  input wire logic dram_busy,
  input wire logic nmi_line,
  input wire logic external_irq_line,
  input wire logic voice_frame_start,
  input wire logic voice_bit_strobe,
  input wire logic periodic_tick_irq,
  output logic irq_take,
  output logic [15:0] irq_vector,
  output logic hold_active
);
  logic [15:0] stack_mem [STK_DEPTH];
  logic [SP_W-1:0] sp_reg;
  logic [SP_W-1:0] sp_dec;
  logic [3:0] mask_reg;
  logic [14:0] ctl_reg;
  logic [RC_W-1:0] repeat_counter;
  logic gmask_reg;
  ilsc_flow_t flow_reg;
  logic [15:0] loop_start_reg;
  logic [15:0] loop_end_reg;
  logic nmi_prev_reg;
  logic ext_prev_reg;
  logic [4:0] voice_cnt_reg;
  logic [SRC_N-1:0] pend_reg;
  logic [SRC_N-1:0] in_service_reg;
  logic [SRC_N-1:0] req;
  logic [SRC_N-1:0] en;
  logic [SRC_N-1:0] set_ev;
  logic [SRC_N-1:0] clr_ev;
  logic [SRC_N-1:0] isr_lowest;
  ilsc_src_t grant_src;
  logic [15:0] grant_vec;
  logic boundary;
  logic take;
  logic voice_ev;
  logic [15:0] popped;

  assign sp_dec = sp_reg - 5'h01;
  assign popped = stack_mem[sp_dec];

  // Return stack; irq entry has the write port over a sequencer push
  always_ff @(posedge core_clk) begin
    if (take) begin
      stack_mem[sp_reg] <= status_in;
    end else if (seq_cmd.push) begin
      stack_mem[sp_reg] <= push_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      sp_reg <= '0;
      pop_data <= 16'h0000;
      status_restore <= 1'b0;
    end else begin
      status_restore <= 1'b0;
      if (take || seq_cmd.push) begin
        sp_reg <= sp_reg + 5'h01;
      end else if (seq_cmd.pop || seq_cmd.reti) begin
        sp_reg <= sp_dec;
        pop_data <= popped;
        status_restore <= seq_cmd.reti;
      end
    end
  end

  // Global mask: entry beats return, return beats the two instructions
  always_ff @(posedge core_clk) begin
    if (reset) begin
      gmask_reg <= GMASK_RST;
    end else if (take) begin
      gmask_reg <= 1'b1;
    end else if (seq_cmd.reti) begin
      gmask_reg <= popped[STAT_GMASK_BIT];
    end else if (seq_cmd.irq_disable_instr) begin
      gmask_reg <= 1'b1;
    end else if (seq_cmd.irq_enable_instr) begin
      gmask_reg <= 1'b0;
    end
  end
  assign global_irq_mask = gmask_reg;

  // I/O writes; a granted wake-up clears hold unless software sets it
  always_ff @(posedge core_clk) begin
    if (reset) begin
      mask_reg <= MASK_RST;
      ctl_reg <= CTL_RST;
    end else begin
      if (io_wr && io_addr == IO_MASK) begin
        mask_reg <= io_wdata[3:0];
      end
      if (io_wr && io_addr == IO_CTL) begin
        ctl_reg <= io_wdata[14:0];
      end else if (take && ctl_reg[CTL_HOLD_BIT] &&
                   (grant_src == SRC_EXT || grant_src == SRC_TICK)) begin
        ctl_reg[CTL_HOLD_BIT] <= 1'b0;
      end
    end
  end
  assign hold_active = ctl_reg[CTL_HOLD_BIT];

  always_ff @(posedge core_clk) begin
    if (reset) begin
      io_rdata <= 16'h0000;
    end else if (io_rd) begin
      case (io_addr)
        IO_MASK: io_rdata <= {12'h000, mask_reg};
        IO_CTL: io_rdata <= {1'b0, ctl_reg};
        IO_RC: io_rdata <= {6'h00, repeat_counter};
        IO_SP: io_rdata <= {11'h000, sp_reg};
        default: io_rdata <= 16'h0000;
      endcase
    end
  end

  // Loop and single-instruction repeat share the counter
  always_ff @(posedge core_clk) begin
    if (reset) begin
      flow_reg <= FLOW_IDLE;
      flow_busy <= 1'b0;
      repeat_counter <= '0;
      loop_start_reg <= 16'h0000;
      loop_end_reg <= 16'h0000;
      loop_jump <= 1'b0;
      loop_target <= 16'h0000;
    end else begin
      loop_jump <= 1'b0;
      case (flow_reg)
        FLOW_IDLE: begin
          if (flow_cmd.rc_load) begin
            repeat_counter <= flow_cmd.rc_value;
          end
          if (flow_cmd.loop_start) begin
            flow_reg <= FLOW_LOOP;
            flow_busy <= 1'b1;
            loop_start_reg <= loop_addr;
            loop_target <= loop_addr;
            loop_end_reg <= loop_addr + {13'h0000, flow_cmd.loop_words_m1};
          end else if (flow_cmd.rpt_start) begin
            flow_reg <= FLOW_RPT;
            flow_busy <= 1'b1;
          end
        end
        FLOW_LOOP: begin
          if (fetch_valid && fetch_pc == loop_end_reg) begin
            if (repeat_counter == '0) begin
              flow_reg <= FLOW_IDLE;
              flow_busy <= 1'b0;
            end else begin
              repeat_counter <= repeat_counter - 10'h001;
              loop_jump <= 1'b1;
              loop_target <= loop_start_reg;
            end
          end
        end
        FLOW_RPT: begin
          if (instr_done) begin
            if (repeat_counter == '0) begin
              flow_reg <= FLOW_IDLE;
              flow_busy <= 1'b0;
            end else begin
              repeat_counter <= repeat_counter - 10'h001;
            end
          end
        end
        default: begin
          flow_reg <= FLOW_IDLE;
          flow_busy <= 1'b0;
        end
      endcase
    end
  end

  // Codec frame counter; frame rate itself sets the 8 kHz recurrence
  always_ff @(posedge core_clk) begin
    if (reset || voice_frame_start) begin
      voice_cnt_reg <= 5'h00;
    end else if (voice_bit_strobe) begin
      voice_cnt_reg <= voice_ev ? 5'h00 : voice_cnt_reg + 5'h01;
    end
  end
  assign voice_ev = voice_bit_strobe && !voice_frame_start &&
                    voice_cnt_reg == VOICE_BITS - 5'h01;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      nmi_prev_reg <= 1'b1;
      ext_prev_reg <= 1'b1;
    end else begin
      nmi_prev_reg <= nmi_line;
      ext_prev_reg <= external_irq_line;
    end
  end

  assign set_ev[SRC_NMI] = nmi_prev_reg && !nmi_line;
  assign set_ev[SRC_SS] = 1'b0;
  assign set_ev[SRC_EXT] = ext_prev_reg && !external_irq_line;
  assign set_ev[SRC_VOICE] = voice_ev;
  assign set_ev[SRC_TICK] = periodic_tick_irq;

  // A new edge in the grant cycle stays pending
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pend_reg <= '0;
    end else begin
      pend_reg <= (pend_reg & ~clr_ev) | set_ev;
    end
  end

  assign req = {pend_reg[4:2], ctl_reg[CTL_SS_BIT], pend_reg[0]};
  assign en = {!gmask_reg && !mask_reg[MASK_TICK_BIT],
               !gmask_reg && !mask_reg[MASK_VOICE_BIT],
               !gmask_reg && !mask_reg[MASK_EXT_BIT],
               !gmask_reg && !mask_reg[MASK_SS_BIT],
               1'b1};

  // Highest enabled request wins, unless higher is in service
  always_comb begin
    logic blocked;
    blocked = 1'b0;
    grant_src = SRC_NONE;
    for (int i = 0; i < SRC_N; i++) begin
      if (!blocked && req[i] && en[i]) begin
        grant_src = ilsc_src_t'(i[2:0]);
        blocked = 1'b1;
      end
      blocked = blocked | in_service_reg[i];
    end
  end

  always_comb begin
    case (grant_src)
      SRC_NMI: grant_vec = VEC_NMI;
      SRC_SS: grant_vec = VEC_SS;
      SRC_EXT: grant_vec = VEC_EXT;
      SRC_VOICE: grant_vec = VEC_VOICE;
      SRC_TICK: grant_vec = VEC_TICK;
      default: grant_vec = VEC_RST;
    endcase
  end

  assign boundary = (instr_done || hold_active) && !flow_busy &&
                    !dram_busy && !irq_take;
  assign take = boundary && grant_src != SRC_NONE;

  generate
    for (genvar g = 0; g < SRC_N; g++) begin : g_src
      assign clr_ev[g] = take && grant_src == ilsc_src_t'(3'(g));
      assign isr_lowest[g] = in_service_reg[g] &&
                             ((in_service_reg & ((5'h01 << g) - 5'h01)) == '0);
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (reset) begin
      in_service_reg <= '0;
    end else begin
      in_service_reg <= (in_service_reg &
                         ~((seq_cmd.reti && !take) ? isr_lowest : '0)) |
                        clr_ev;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      irq_take <= 1'b0;
      irq_vector <= VEC_RST;
    end else begin
      irq_take <= take;
      if (take) begin
        irq_vector <= grant_vec;
      end
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  property p_entry_push;
    take |=> sp_reg == $past(sp_reg) + 5'h01 && gmask_reg;
  endproperty
  a_entry_push: assert property (p_entry_push)
    else $error("entry did not push and mask");
  property p_wrap;
    (sp_reg == 5'h1F && seq_cmd.push && !take) |=> sp_reg == 5'h00;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("stack pointer did not wrap");
  property p_no_grant_busy;
    (flow_busy || dram_busy) |=> !irq_take;
  endproperty
  a_no_grant_busy: assert property (p_no_grant_busy)
    else $error("grant while busy");
  property p_ext_mask;
    (irq_take && irq_vector == VEC_EXT) |->
      !$past(mask_reg[MASK_EXT_BIT]) && !$past(gmask_reg);
  endproperty
  a_ext_mask: assert property (p_ext_mask)
    else $error("masked external granted");
  property p_nmi_first;
    (grant_src != SRC_NONE && req[SRC_NMI] && in_service_reg == '0 &&
     boundary) |=> irq_vector == VEC_NMI;
  endproperty
  a_nmi_first: assert property (p_nmi_first)
    else $error("nmi not first");
  property p_reset_vals;
    $past(reset) |-> mask_reg == MASK_RST && !ctl_reg[CTL_SS_BIT];
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("reset values wrong");
  property p_hold_wake;
    (take && hold_active && grant_src == SRC_TICK &&
     !(io_wr && io_addr == IO_CTL)) |=> !hold_active;
  endproperty
  a_hold_wake: assert property (p_hold_wake)
    else $error("hold not cleared");
  property p_loop_back;
    (flow_reg == FLOW_LOOP && fetch_valid && fetch_pc == loop_end_reg &&
     repeat_counter != '0) |=>
      loop_jump && loop_target == loop_start_reg &&
      repeat_counter == $past(repeat_counter) - 10'h001;
  endproperty
  a_loop_back: assert property (p_loop_back)
    else $error("loop did not jump back");
  property p_ext_edge;
    $fell(external_irq_line) |=> pend_reg[SRC_EXT] || irq_take;
  endproperty
  a_ext_edge: assert property (p_ext_edge)
    else $error("falling edge lost");
  property p_reti;
    seq_cmd.reti && !take |=> gmask_reg == pop_data[STAT_GMASK_BIT];
  endproperty
  a_reti: assert property (p_reti)
    else $error("status not restored");

  c_nested: cover property (irq_take ##[1:50] irq_take);
  c_loop_end: cover property (flow_reg == FLOW_LOOP ##1 flow_reg == FLOW_IDLE);
  c_hold_wake: cover property (hold_active ##1 !hold_active);
endmodule
`default_nettype wire

/* src/ilsc_pkg.sv */
/*
  Shared constants and types for the interrupt, loop and stack control
  block. Assumes a single processor clock and synchronous reset.
*/
package ilsc_pkg;
  localparam int SP_W = 5;
  localparam int STK_DEPTH = 32;
  localparam int RC_W = 10;
  localparam int SRC_N = 5;
  // I/O port numbers
  localparam logic [4:0] IO_MASK = 5'h04;
  localparam logic [4:0] IO_CTL = 5'h07;
  localparam logic [4:0] IO_RC = 5'h0C;
  localparam logic [4:0] IO_SP = 5'h0F;
  // Reset values
  localparam logic [3:0] MASK_RST = 4'hF;
  localparam logic [14:0] CTL_RST = 15'h0000;
  localparam logic GMASK_RST = 1'b1;
  // Field positions
  localparam int MASK_SS_BIT = 3;
  localparam int MASK_TICK_BIT = 2;
  localparam int MASK_VOICE_BIT = 1;
  localparam int MASK_EXT_BIT = 0;
  localparam int CTL_SS_BIT = 4;
  localparam int CTL_HOLD_BIT = 10;
  localparam int STAT_GMASK_BIT = 9;
  // Vectors
  localparam logic [15:0] VEC_RST = 16'h0000;
  localparam logic [15:0] VEC_NMI = 16'h0002;
  localparam logic [15:0] VEC_SS = 16'h0004;
  localparam logic [15:0] VEC_EXT = 16'h0006;
  localparam logic [15:0] VEC_VOICE = 16'h0008;
  localparam logic [15:0] VEC_TICK = 16'h000A;
  // Codec bits per frame
  localparam logic [4:0] VOICE_BITS = 5'h10;

  typedef enum logic [2:0] {
    SRC_NMI = 3'b000,
    SRC_SS = 3'b001,
    SRC_EXT = 3'b010,
    SRC_VOICE = 3'b011,
    SRC_TICK = 3'b100,
    SRC_NONE = 3'b111
  } ilsc_src_t;

  typedef enum logic [1:0] {
    FLOW_IDLE = 2'b00,
    FLOW_LOOP = 2'b01,
    FLOW_RPT = 2'b10
  } ilsc_flow_t;

  typedef struct packed {
    logic push;
    logic pop;
    logic reti;
    logic irq_enable_instr;
    logic irq_disable_instr;
  } ilsc_seq_cmd_t;

  typedef struct packed {
    logic loop_start;
    logic [2:0] loop_words_m1;
    logic rpt_start;
    logic rc_load;
    logic [9:0] rc_value;
  } ilsc_flow_cmd_t;
endpackage

/* verif/ilsc_src_model.sv */
/*
  Request-source model: edge-triggered request lines, codec bit timing
  and timer tick. Assumes the bench calls its tasks from one process.
*/
`timescale 1ns/1ns
`default_nettype none
module ilsc_src_model (
  input wire logic core_clk,
  output var logic nmi_line,
  output var logic external_irq_line,
  output var logic voice_frame_start,
  output var logic voice_bit_strobe,
  output var logic periodic_tick_irq
);
  initial begin
    nmi_line = 1'b1;
    external_irq_line = 1'b1;
    voice_frame_start = 1'b0;
    voice_bit_strobe = 1'b0;
    periodic_tick_irq = 1'b0;
  end
  // Held low two cycles so a level sampler and an edge sampler differ
  task automatic fall(input logic nmi);
    @(posedge core_clk);
    #1;
    if (nmi) nmi_line = 1'b0;
    else external_irq_line = 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    nmi_line = 1'b1;
    external_irq_line = 1'b1;
  endtask
  task automatic strobes(input int n);
    repeat (n) begin
      @(posedge core_clk);
      #1;
      voice_bit_strobe = 1'b1;
      @(posedge core_clk);
      #1;
      voice_bit_strobe = 1'b0;
    end
  endtask
  task automatic frame(input int n);
    @(posedge core_clk);
    #1;
    voice_frame_start = 1'b1;
    @(posedge core_clk);
    #1;
    voice_frame_start = 1'b0;
    strobes(n);
  endtask
  // Returns right after the edge that samples the pulse
  task automatic tick();
    @(posedge core_clk);
    #1;
    periodic_tick_irq = 1'b1;
    @(posedge core_clk);
    #1;
    periodic_tick_irq = 1'b0;
  endtask
endmodule
`default_nettype wire

/* verif/tb.sv */
/*
  Self-checking bench for the interrupt, loop and stack control block.
  Assumes the source model drives all request inputs.
*/
`timescale 1ns/1ns
`default_nettype none
module tb;
  import ilsc_pkg::*;
  logic core_clk, reset, io_wr, io_rd, status_restore, global_irq_mask;
  logic [4:0] io_addr;
  logic [15:0] io_wdata, io_rdata, push_data, status_in, pop_data;
  logic [15:0] loop_addr, fetch_pc, loop_target, irq_vector;
  ilsc_seq_cmd_t seq_cmd;
  ilsc_flow_cmd_t flow_cmd;
  logic fetch_valid, loop_jump, flow_busy, instr_done, irq_take;
  logic hold_active, nmi_line, external_irq_line, voice_frame_start;
  logic voice_bit_strobe, periodic_tick_irq, dram_busy;
  int mismatches = 0;
  int total_checks = 0;
  ilsc_ctrl i_dut (.core_clk, .reset, .io_addr, .io_wr, .io_rd, .io_wdata,
    .io_rdata, .seq_cmd, .push_data, .status_in, .pop_data, .status_restore,
    .global_irq_mask, .flow_cmd, .loop_addr, .fetch_valid, .fetch_pc,
    .loop_jump, .loop_target, .flow_busy, .instr_done, .dram_busy,
    .nmi_line, .external_irq_line, .voice_frame_start, .voice_bit_strobe,
    .periodic_tick_irq, .irq_take, .irq_vector, .hold_active);
  ilsc_src_model i_src (.core_clk, .nmi_line, .external_irq_line,
    .voice_frame_start, .voice_bit_strobe, .periodic_tick_irq);
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #200000;
    mismatches++;
    results();
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic chk(input string w, input logic [15:0] e,
                     input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", w, e, g);
      mismatches++;
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    cyc(1);
    io_wr = 1'b0;
  endtask
  task automatic rc(input string w, input logic [4:0] a, input logic [15:0] e);
    io_addr = a;
    io_rd = 1'b1;
    cyc(1);
    io_rd = 1'b0;
    chk(w, e, io_rdata);
  endtask
  // 0 push, 1 pop, 2 return, 3 enable, 4 disable
  task automatic seq(input int k, input logic [15:0] d);
    push_data = d;
    seq_cmd.push = (k == 0);
    seq_cmd.pop = (k == 1);
    seq_cmd.reti = (k == 2);
    seq_cmd.irq_enable_instr = (k == 3);
    seq_cmd.irq_disable_instr = (k == 4);
    cyc(1);
    seq_cmd = '0;
  endtask
  task automatic take(input logic [15:0] vec, input logic d);
    int n;
    n = 0;
    instr_done = d;
    while (irq_take !== 1'b1 && n < 8) begin
      cyc(1);
      n++;
    end
    instr_done = 1'b0;
    chk("irq_take", 16'h0001, {15'h0000, irq_take});
    chk("irq_vector", vec, irq_vector);
    chk("gmask entry", 16'h0001, {15'h0000, global_irq_mask});
  endtask
  task automatic no_take();
    instr_done = 1'b1;
    repeat (4) begin
      cyc(1);
      chk("no take", 16'h0000, {15'h0000, irq_take});
    end
    instr_done = 1'b0;
  endtask
  task automatic ret();
    seq(2, 16'h0000);
    chk("restore", 16'h0001, {15'h0000, status_restore});
    chk("pop status", status_in, pop_data);
    cyc(1);
    chk("gmask back", {15'h0000, status_in[STAT_GMASK_BIT]},
        {15'h0000, global_irq_mask});
  endtask
  task automatic t_reset();
    rc("mask", IO_MASK, 16'h000F);
    rc("ctl", IO_CTL, 16'h0000);
    rc("sp", IO_SP, 16'h0000);
    chk("gmask", 16'h0001, {15'h0000, global_irq_mask});
    rc("unmapped", 5'h03, 16'h0000);
    wr(IO_SP, 16'h0007);
    rc("sp ro", IO_SP, 16'h0000);
  endtask
  task automatic t_stack();
    seq(0, 16'h1234);
    seq(0, 16'hABCD);
    rc("sp two", IO_SP, 16'h0002);
    seq(1, 16'h0000);
    chk("pop1", 16'hABCD, pop_data);
    seq(1, 16'h0000);
    chk("pop2", 16'h1234, pop_data);
    seq(1, 16'h0000);
    rc("sp under", IO_SP, 16'h001F);
    seq(0, 16'h0000);
    rc("sp over", IO_SP, 16'h0000);
  endtask
  task automatic t_ext();
    wr(IO_MASK, 16'h000E);
    seq(3, 16'h0000);
    chk("irq_enable_instr", 16'h0000, {15'h0000, global_irq_mask});
    seq(4, 16'h0000);
    i_src.fall(1'b0);
    no_take();
    seq(3, 16'h0000);
    take(VEC_EXT, 1'b1);
    rc("sp entry", IO_SP, 16'h0001);
    ret();
    seq(4, 16'h0000);
    i_src.fall(1'b0);
    i_src.fall(1'b1);
    take(VEC_NMI, 1'b1);
    ret();
    take(VEC_EXT, 1'b1);
    ret();
    rc("sp back", IO_SP, 16'h0000);
  endtask
  task automatic t_loop();
    int jumps;
    int takes;
    jumps = 0;
    takes = 0;
    flow_cmd.rc_load = 1'b1;
    flow_cmd.rc_value = 10'h002;
    cyc(1);
    flow_cmd = '0;
    rc("count", IO_RC, 16'h0002);
    loop_addr = 16'h0010;
    flow_cmd.loop_start = 1'b1;
    flow_cmd.loop_words_m1 = 3'h1;
    cyc(1);
    flow_cmd = '0;
    chk("busy", 16'h0001, {15'h0000, flow_busy});
    i_src.fall(1'b0);
    for (int p = 0; p < 6; p++) begin
      fetch_valid = 1'b1;
      fetch_pc = 16'h0010 + 16'(p % 2);
      instr_done = 1'b1;
      cyc(1);
      if (loop_jump === 1'b1) begin
        jumps++;
        chk("target", 16'h0010, loop_target);
      end
      if (irq_take === 1'b1) takes++;
    end
    fetch_valid = 1'b0;
    instr_done = 1'b0;
    chk("jumps", 16'h0002, 16'(jumps));
    chk("loop takes", 16'h0000, 16'(takes));
    chk("idle", 16'h0000, {15'h0000, flow_busy});
    flow_cmd.rc_load = 1'b1;
    flow_cmd.rc_value = 10'h001;
    cyc(1);
    flow_cmd = '0;
    flow_cmd.rpt_start = 1'b1;
    cyc(1);
    flow_cmd = '0;
    instr_done = 1'b1;
    cyc(1);
    chk("rpt busy", 16'h0001, {15'h0000, flow_busy});
    cyc(1);
    instr_done = 1'b0;
    chk("rpt idle", 16'h0000, {15'h0000, flow_busy});
    chk("rpt take", 16'h0000, {15'h0000, irq_take});
    dram_busy = 1'b1;
    no_take();
    dram_busy = 1'b0;
    take(VEC_EXT, 1'b1);
    ret();
  endtask
  task automatic t_misc();
    wr(IO_MASK, 16'h0007);
    wr(IO_CTL, 16'h0010);
    take(VEC_SS, 1'b1);
    wr(IO_CTL, 16'h0000);
    ret();
    wr(IO_MASK, 16'h000D);
    i_src.frame(15);
    no_take();
    i_src.strobes(1);
    take(VEC_VOICE, 1'b1);
    ret();
    wr(IO_MASK, 16'h000B);
    status_in = 16'h0200;
    wr(IO_CTL, 16'h0400);
    chk("hold", 16'h0001, {15'h0000, hold_active});
    i_src.tick();
    take(VEC_TICK, 1'b0);
    chk("hold end", 16'h0000, {15'h0000, hold_active});
    rc("ctl hold", IO_CTL, 16'h0000);
    ret();
  endtask
  initial begin
    reset = 1'b1;
    io_addr = 5'h00;
    io_wdata = 16'h0000;
    io_wr = 1'b0;
    io_rd = 1'b0;
    seq_cmd = '0;
    push_data = 16'h0000;
    status_in = 16'h0123;
    flow_cmd = '0;
    loop_addr = 16'h0000;
    fetch_valid = 1'b0;
    fetch_pc = 16'h0000;
    instr_done = 1'b0;
    dram_busy = 1'b0;
    cyc(6);
    reset = 1'b0;
    t_reset();
    t_stack();
    t_ext();
    t_loop();
    t_misc();
    results();
  end
endmodule
`default_nettype wire
